// ===== include/tec_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 32-bit APB, byte addresses
// Notes: Counter n sits at CNT_BASE + n * 0x20
`ifndef TEC_DEFINES_SVH
`define TEC_DEFINES_SVH
`define TEC_NUM 8
`define TEC_AW 12
`define TEC_OFF_CTRL 12'h000
`define TEC_OFF_TIME 12'h004
`define TEC_OFF_NV 12'h008
`define TEC_CNT_PAGE 4'h1
`define TEC_OFF_PRESET 5'h00
`define TEC_OFF_COMPARE 5'h04
`define TEC_OFF_COUNT 5'h08
`define TEC_OFF_FROZEN 5'h0c
`define TEC_OFF_FTIME 5'h10
`define TEC_OFF_FLAGS 5'h14
`define TEC_RST_CTRL 8'h00
`define TEC_RST_VAL 32'h0000_0000
`define TEC_NV_RESTORE_BIT 0
`define TEC_CLK_PERIOD_NS 25
`define TEC_TICK_NS 1000000000
`define TEC_TICK_CYCLES (`TEC_TICK_NS / `TEC_CLK_PERIOD_NS)
`endif

// ===== include/tec_pkg.sv
// Purpose: Types shared by the event counter bank
// Assumes: Eight counters
// Notes: Operand groups are one bit per counter
package tec_pkg;
    typedef struct packed {
        logic [7:0] up;
        logic [7:0] down;
        logic [7:0] inhibit;
        logic [7:0] load_preset_select;
        logic [7:0] clear_req;
        logic [7:0] capture_and_clear;
        logic [7:0] capture_and_continue;
    } tec_ops_t;
    typedef struct packed {
        logic [7:0] count_above_compare;
        logic [7:0] count_equals_compare;
        logic [7:0] count_under_compare;
    } tec_flags_t;
    typedef enum logic [1:0] {
        TEC_IDLE = 2'b01,
        TEC_ACK = 2'b10
    } tec_bus_t;
    typedef enum logic [3:0] {
        TEC_R_CTRL, TEC_R_TIME, TEC_R_NV, TEC_R_PRESET, TEC_R_COMPARE,
        TEC_R_COUNT, TEC_R_FROZEN, TEC_R_FTIME, TEC_R_FLAGS, TEC_R_NONE
    } tec_reg_t;
endpackage : tec_pkg

// ===== testbench/tec_ops_src.sv
// Purpose: Operand source standing in for surrounding logic
// Assumes: Same clock as the counter bank
// Notes: Calls start right after a rising edge
`timescale 1ns/1ps
module tec_ops_src import tec_pkg::*; (
    // Clock
    input wire logic clock,
    // Operands
    output tec_ops_t ops
);
    tec_ops_t ops_r = '0;
    assign ops = ops_r;
    task automatic set_op(input int f, input int n, input logic v);
        ops_r[(6 - f) * 8 + n] <= v;
        repeat (2) @(posedge clock);
    endtask : set_op
    // Up and down rise together on one counter
    task automatic pair(input int n);
        ops_r.up[n] <= 1'b1;
        ops_r.down[n] <= 1'b1;
        repeat (2) @(posedge clock);
        ops_r.up[n] <= 1'b0;
        ops_r.down[n] <= 1'b0;
        repeat (2) @(posedge clock);
    endtask : pair
    task automatic pulse(input int f, input int n);
        set_op(f, n, 1'b1);
        set_op(f, n, 1'b0);
        repeat (2) @(posedge clock);
    endtask : pulse
endmodule : tec_ops_src

// ===== testbench/tec_top_sva.sv
// Purpose: Port checker for the event counter bank
// Assumes: One clock, resetn active low
// Notes: Bound to tec_top below
`timescale 1ns/1ps
module tec_top_sva import tec_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Operands and flags
    input wire tec_ops_t ops,
    input wire tec_flags_t flags
);
    // ==========
    // Helpers
    logic [7:0] f_ab, f_eq, f_un, inh1_r, inh2_r;
    logic [2:0] quiet_r;
    tec_ops_t ops_r;
    assign f_ab = flags.count_above_compare;
    assign f_eq = flags.count_equals_compare;
    assign f_un = flags.count_under_compare;
    // Quiet counts cycles with steady operands and no bus traffic
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            inh1_r <= 8'h00;
            inh2_r <= 8'h00;
            ops_r <= '0;
            quiet_r <= 3'h0;
        end else begin
            inh1_r <= ops.inhibit;
            inh2_r <= inh1_r;
            ops_r <= ops;
            quiet_r <= (ops != ops_r || psel) ? 3'h0 : (quiet_r == 3'h7 ? quiet_r : quiet_r + 3'h1);
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    property p_flag_excl;
        ((f_ab & f_eq) | (f_ab & f_un) | (f_eq & f_un)) == 8'h00;
    endproperty
    a_flag_excl: assert property (p_flag_excl) else $error("flags not exclusive");
    property p_inh_flags;
        (ops.inhibit & inh1_r & inh2_r & (f_ab | f_eq | f_un)) == 8'h00;
    endproperty
    a_inh_flags: assert property (p_inh_flags) else $error("flag active under inhibit");
    property p_quiet;
        quiet_r == 3'h7 |-> $stable(flags);
    endproperty
    a_quiet: assert property (p_quiet) else $error("flags moved with steady operands");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
    property p_ready_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready late");
    property p_ready_idle;
        !psel |=> !pready;
    endproperty
    a_ready_idle: assert property (p_ready_idle) else $error("ready without select");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_err_data;
        pready && pslverr |-> prdata == 32'h0;
    endproperty
    a_err_data: assert property (p_err_data) else $error("data on refused access");
    c_err: cover property (pready && pslverr);
    c_inh: cover property (|(ops.inhibit & inh2_r));
    c_eq: cover property (|f_eq);
endmodule : tec_top_sva

bind tec_top tec_top_sva chk_u (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ops(ops), .flags(flags));

// ===== testbench/test_transition_event_counter.sv
// Purpose: Directed test of the event counter bank over APB
// Assumes: Time tick of 64 cycles; captures follow a time write within a few cycles
// Notes: Operands come from the source model
`timescale 1ns/1ps
`include "tec_defines.svh"
module test_transition_event_counter import tec_pkg::*;;
    localparam int UP = 0, DN = 1, INH = 2, SEL = 3, CLR = 4, CAPZ = 5, CAPK = 6;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, power_fail_n = 1'b1, pready, pslverr, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [31:0] cmpv [3] = '{32'h0, 32'hffff_ffff, 32'hffff_fffe};
    logic [31:0] flg [3] = '{32'h4, 32'h2, 32'h1};
    tec_ops_t ops;
    tec_flags_t flags;
    int errors = 0, checked = 0, cycles = 0;
    always #12.5 clock = ~clock;
    tec_top #(.TICK_CYCLES(64)) dut_u (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ops(ops), .power_fail_n(power_fail_n), .flags(flags));
    tec_ops_src src_u (.clock(clock), .ops(ops));
    // ==========
    // Tasks
    task automatic results;
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            results();
        end
    end
    task automatic chk(input string s, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", s, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string s);
        apb(1'b0, a, 32'h0);
        chk(s, exp, rd);
    endtask : rdc
    function automatic logic [11:0] ca(input int n, input logic [4:0] o);
        return {`TEC_CNT_PAGE, n[2:0], o};
    endfunction : ca
    // ==========
    // Tests
    initial begin
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        rdc(`TEC_OFF_CTRL, 32'h0, "ctrl");
        rdc(ca(0, `TEC_OFF_COUNT), 32'h0, "count0");
        $display("test reset done");
        apb(1'b1, ca(0, `TEC_OFF_PRESET), 32'h7fff_ffff);
        apb(1'b1, ca(1, `TEC_OFF_PRESET), 32'h5);
        src_u.set_op(SEL, 0, 1'b1);
        apb(1'b1, `TEC_OFF_CTRL, 32'h3);
        rdc(ca(0, `TEC_OFF_COUNT), 32'h7fff_ffff, "count0");
        rdc(ca(1, `TEC_OFF_COUNT), 32'h0, "count1");
        src_u.pulse(UP, 0);
        rdc(ca(0, `TEC_OFF_COUNT), 32'h8000_0000, "count0");
        src_u.pulse(DN, 0);
        rdc(ca(0, `TEC_OFF_COUNT), 32'h7fff_ffff, "count0");
        src_u.pulse(DN, 1);
        rdc(ca(1, `TEC_OFF_COUNT), 32'hffff_ffff, "count1");
        $display("test wrap done");
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, ca(1, `TEC_OFF_COMPARE), cmpv[i]);
            rdc(ca(1, `TEC_OFF_FLAGS), flg[i], "flags1");
            chk("flag pins", flg[i], {29'h0, flags.count_under_compare[1], flags.count_equals_compare[1],
                flags.count_above_compare[1]});
        end
        $display("test compare done");
        src_u.set_op(SEL, 1, 1'b1);
        rdc(ca(1, `TEC_OFF_COUNT), 32'h5, "count1");
        apb(1'b1, ca(1, `TEC_OFF_PRESET), 32'h9);
        src_u.set_op(SEL, 1, 1'b0);
        rdc(ca(1, `TEC_OFF_COUNT), 32'h5, "count1");
        src_u.pulse(CLR, 1);
        rdc(ca(1, `TEC_OFF_COUNT), 32'h0, "count1");
        src_u.set_op(SEL, 1, 1'b1);
        src_u.pulse(UP, 1);
        rdc(ca(1, `TEC_OFF_COUNT), 32'ha, "count1");
        src_u.pulse(CLR, 1);
        rdc(ca(1, `TEC_OFF_COUNT), 32'h9, "count1");
        $display("test preset done");
        apb(1'b1, `TEC_OFF_TIME, 32'h123);
        src_u.pulse(CAPK, 1);
        rdc(ca(1, `TEC_OFF_FROZEN), 32'h9, "frozen1");
        rdc(ca(1, `TEC_OFF_COUNT), 32'h9, "count1");
        rdc(ca(1, `TEC_OFF_FTIME), 32'h123, "ftime1");
        apb(1'b1, `TEC_OFF_TIME, 32'h0);
        repeat (70) @(posedge clock);
        rdc(`TEC_OFF_TIME, 32'h1, "time");
        src_u.pulse(UP, 1);
        src_u.pulse(CAPZ, 1);
        rdc(ca(1, `TEC_OFF_FROZEN), 32'ha, "frozen1");
        rdc(ca(1, `TEC_OFF_COUNT), 32'h0, "count1");
        $display("test capture done");
        src_u.set_op(INH, 1, 1'b1);
        src_u.pulse(UP, 1);
        rdc(ca(1, `TEC_OFF_COUNT), 32'h0, "count1");
        rdc(ca(1, `TEC_OFF_FLAGS), 32'h0, "flags1");
        src_u.set_op(INH, 1, 1'b0);
        rdc(ca(1, `TEC_OFF_FLAGS), 32'h1, "flags1");
        src_u.pair(1);
        rdc(ca(1, `TEC_OFF_COUNT), 32'h0, "count1");
        $display("test inhibit done");
        src_u.set_op(UP, 0, 1'b1);
        rdc(ca(0, `TEC_OFF_COUNT), 32'h8000_0000, "count0");
        rdc(ca(0, `TEC_OFF_COUNT), 32'h8000_0000, "count0");
        src_u.set_op(UP, 0, 1'b0);
        rdc(ca(0, `TEC_OFF_COUNT), 32'h8000_0000, "count0");
        apb(1'b1, ca(0, `TEC_OFF_COUNT), 32'h1234);
        rdc(ca(0, `TEC_OFF_COUNT), 32'h8000_0000, "count0");
        rdc(ca(1, `TEC_OFF_PRESET), 32'h9, "preset1");
        rdc(ca(1, `TEC_OFF_COMPARE), 32'hffff_fffe, "compare1");
        apb(1'b0, 12'h00c, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        $display("test access done");
        power_fail_n <= 1'b0;
        repeat (6) @(posedge clock);
        power_fail_n <= 1'b1;
        repeat (4) @(posedge clock);
        src_u.pulse(DN, 0);
        apb(1'b1, `TEC_OFF_NV, 32'h1);
        rdc(ca(0, `TEC_OFF_COUNT), 32'h8000_0000, "count0");
        rdc(ca(1, `TEC_OFF_FROZEN), 32'ha, "frozen1");
        rdc(`TEC_OFF_NV, 32'h1, "store valid");
        $display("test power done");
        results();
    end
endmodule : test_transition_event_counter

// ===== verilog/tec_top.sv
// Purpose: Bank of eight signed up/down transition counters with APB access
// Assumes: Operands come from logic on the same clock
// Notes: Time base counts seconds, loadable by software
//
// Notes on behaviour
// - Eight identical counters, each configured on its own.
// - Only low-to-high transitions of count inputs change the count.
// - Up edge adds one; maximum wraps to minimum.
// - Down edge subtracts one; minimum wraps to maximum.
// - Inhibit stops counting and forces all output flags inactive.
// - Count compared with compare value; above, equal, under flags exclusive.
// - On enable, load preset if select high, else zero.
// - While running, select rising edge loads preset; falling edge ignored.
// - Clear request loads preset if select high, else zero.
// - Capture-and-clear freezes count with time, then zeroes count.
// - Capture-and-continue freezes count with time, count unchanged.
// - Count, frozen count and frozen time always readable.
// - Signed preset held per counter, loadable before or while running.
// - Power loss saves count and frozen count; restore brings them back.
`timescale 1ns/1ps
`include "tec_defines.svh"

module tec_top import tec_pkg::*; #(
    parameter int TICK_CYCLES = `TEC_TICK_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`TEC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Count operands
    input wire tec_ops_t ops,
    // Power-fail pin, low while supply is being lost
    input wire logic power_fail_n,
    // Comparison flags
    output tec_flags_t flags
);

    // ==================================================
    // Reset release
    logic rst_s1_r;
    logic rst_n;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_s1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n <= rst_s1_r;
        end
    end

    // ==================================================
    // Address decode
    function automatic tec_reg_t tec_dec(input logic [`TEC_AW-1:0] a);
        tec_reg_t r;
        r = TEC_R_NONE;
        if (a[11:8] == `TEC_CNT_PAGE) begin
            unique case (a[4:0])
                `TEC_OFF_PRESET: r = TEC_R_PRESET;
                `TEC_OFF_COMPARE: r = TEC_R_COMPARE;
                `TEC_OFF_COUNT: r = TEC_R_COUNT;
                `TEC_OFF_FROZEN: r = TEC_R_FROZEN;
                `TEC_OFF_FTIME: r = TEC_R_FTIME;
                `TEC_OFF_FLAGS: r = TEC_R_FLAGS;
                default: r = TEC_R_NONE;
            endcase
        end else if (a == `TEC_OFF_CTRL) begin
            r = TEC_R_CTRL;
        end else if (a == `TEC_OFF_TIME) begin
            r = TEC_R_TIME;
        end else if (a == `TEC_OFF_NV) begin
            r = TEC_R_NV;
        end
        return r;
    endfunction : tec_dec

    // ==================================================
    // Bus handshake: one wait state, write lands on the pready edge
    tec_bus_t st_r, st_nxt;
    tec_reg_t sel;
    logic [2:0] idx;
    logic wr_go;
    logic [31:0] rd_data, prdata_nxt;
    logic pslverr_nxt;
    logic signed [31:0] cnt_r [8];
    logic signed [31:0] frz_r [8];
    logic [31:0] ftm_r [8];
    logic signed [31:0] preset_r [8];
    logic signed [31:0] cmp_r [8];
    logic [7:0] en_r;
    logic [31:0] time_r;
    logic nv_valid_r;
    tec_flags_t flags_r;

    assign sel = tec_dec(paddr);
    assign idx = paddr[7:5];
    assign wr_go = (st_r == TEC_ACK) && psel && penable && pwrite;

    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (sel)
            TEC_R_CTRL: rd_data = {24'h00_0000, en_r};
            TEC_R_TIME: rd_data = time_r;
            TEC_R_NV: rd_data = {31'h0000_0000, nv_valid_r};
            TEC_R_PRESET: rd_data = preset_r[idx];
            TEC_R_COMPARE: rd_data = cmp_r[idx];
            TEC_R_COUNT: rd_data = cnt_r[idx];
            TEC_R_FROZEN: rd_data = frz_r[idx];
            TEC_R_FTIME: rd_data = ftm_r[idx];
            TEC_R_FLAGS: rd_data = {29'h0000_0000, flags_r.count_under_compare[idx],
                flags_r.count_equals_compare[idx], flags_r.count_above_compare[idx]};
            TEC_R_NONE: rd_data = 32'h0000_0000;
        endcase
    end

    always_comb begin
        st_nxt = TEC_IDLE;
        prdata_nxt = prdata;
        pslverr_nxt = 1'b0;
        if (st_r == TEC_IDLE && psel && penable) begin
            st_nxt = TEC_ACK;
            prdata_nxt = pwrite ? 32'h0000_0000 : rd_data;
            pslverr_nxt = (sel == TEC_R_NONE);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= TEC_IDLE;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            st_r <= st_nxt;
            prdata <= prdata_nxt;
            pready <= (st_nxt == TEC_ACK);
            pslverr <= pslverr_nxt;
        end
    end

    // ==================================================
    // Settings and time base
    logic [7:0] en_nxt;
    logic [31:0] time_nxt;
    logic [31:0] presc_r, presc_nxt;
    logic signed [31:0] preset_nxt [8];
    logic signed [31:0] cmp_nxt [8];
    logic nv_restore;

    assign nv_restore = wr_go && (sel == TEC_R_NV) && pwdata[`TEC_NV_RESTORE_BIT];

    always_comb begin
        en_nxt = en_r;
        time_nxt = time_r;
        presc_nxt = presc_r + 32'h0000_0001;
        for (int k = 0; k < `TEC_NUM; k++) begin
            preset_nxt[k] = preset_r[k];
            cmp_nxt[k] = cmp_r[k];
        end
        if (presc_r == 32'(TICK_CYCLES - 1)) begin
            presc_nxt = 32'h0000_0000;
            time_nxt = time_r + 32'h0000_0001;
        end
        if (wr_go) begin
            if (sel == TEC_R_CTRL) begin
                en_nxt = pwdata[7:0];
            end
            if (sel == TEC_R_TIME) begin
                time_nxt = pwdata;
                presc_nxt = 32'h0000_0000;
            end
            if (sel == TEC_R_PRESET) begin
                preset_nxt[idx] = pwdata;
            end
            if (sel == TEC_R_COMPARE) begin
                cmp_nxt[idx] = pwdata;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            en_r <= `TEC_RST_CTRL;
            time_r <= `TEC_RST_VAL;
            presc_r <= `TEC_RST_VAL;
            for (int k = 0; k < `TEC_NUM; k++) begin
                preset_r[k] <= `TEC_RST_VAL;
                cmp_r[k] <= `TEC_RST_VAL;
            end
        end else begin
            en_r <= en_nxt;
            time_r <= time_nxt;
            presc_r <= presc_nxt;
            for (int k = 0; k < `TEC_NUM; k++) begin
                preset_r[k] <= preset_nxt[k];
                cmp_r[k] <= cmp_nxt[k];
            end
        end
    end

    // ==================================================
    // Power-fail pin filter and retention store
    logic pf_s1_r, pf_s2_r, pf_s3_r, pf_lvl_r, pf_lvl_nxt, pf_save;
    logic signed [31:0] nv_cnt_r [8];
    logic signed [31:0] nv_frz_r [8];

    always_comb begin
        pf_lvl_nxt = pf_lvl_r;
        if (pf_s2_r == pf_s3_r) begin
            pf_lvl_nxt = pf_s3_r;
        end
    end
    assign pf_save = pf_lvl_r && !pf_lvl_nxt;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pf_s1_r <= 1'b1;
            pf_s2_r <= 1'b1;
            pf_s3_r <= 1'b1;
            pf_lvl_r <= 1'b1;
        end else begin
            pf_s1_r <= power_fail_n;
            pf_s2_r <= pf_s1_r;
            pf_s3_r <= pf_s2_r;
            pf_lvl_r <= pf_lvl_nxt;
        end
    end

    // save on power loss; store is kept through reset
    always_ff @(posedge clock) begin
        if (pf_save) begin
            nv_valid_r <= 1'b1;
            for (int k = 0; k < `TEC_NUM; k++) begin
                nv_cnt_r[k] <= cnt_r[k];
                nv_frz_r[k] <= frz_r[k];
            end
        end
    end

    // ==================================================
    // Counters
    tec_ops_t prev_r;
    logic [7:0] en_prev_r;
    logic signed [31:0] cnt_nxt [8];
    logic signed [31:0] frz_nxt [8];
    logic [31:0] ftm_nxt [8];
    logic [2:0] flg_nxt [8];

    for (genvar i = 0; i < `TEC_NUM; i++) begin : g_cnt
        logic up_e, dn_e, sel_e, clr_e, cc_e, ck_e, live;
        assign up_e = ops.up[i] && !prev_r.up[i];
        assign dn_e = ops.down[i] && !prev_r.down[i];
        assign sel_e = ops.load_preset_select[i] && !prev_r.load_preset_select[i];
        assign clr_e = ops.clear_req[i] && !prev_r.clear_req[i];
        assign cc_e = ops.capture_and_clear[i] && !prev_r.capture_and_clear[i];
        assign ck_e = ops.capture_and_continue[i] && !prev_r.capture_and_continue[i];
        assign live = en_r[i] && !ops.inhibit[i];

        always_comb begin
            cnt_nxt[i] = cnt_r[i];
            frz_nxt[i] = frz_r[i];
            ftm_nxt[i] = ftm_r[i];
            if (nv_restore) begin
                cnt_nxt[i] = nv_cnt_r[i];
                frz_nxt[i] = nv_frz_r[i];
            end else if (en_r[i] && !en_prev_r[i]) begin
                cnt_nxt[i] = ops.load_preset_select[i] ? preset_r[i] : `TEC_RST_VAL;
            end else if (en_r[i]) begin
                if (cc_e || ck_e) begin
                    frz_nxt[i] = cnt_r[i];
                    ftm_nxt[i] = time_r;
                end
                if (cc_e) begin
                    cnt_nxt[i] = `TEC_RST_VAL;
                end else if (clr_e) begin
                    cnt_nxt[i] = ops.load_preset_select[i] ? preset_r[i] : `TEC_RST_VAL;
                end else if (sel_e) begin
                    cnt_nxt[i] = preset_r[i];
                end else if (!ops.inhibit[i] && up_e && !dn_e) begin
                    cnt_nxt[i] = cnt_r[i] + 32'sd1;
                end else if (!ops.inhibit[i] && dn_e && !up_e) begin
                    cnt_nxt[i] = cnt_r[i] - 32'sd1;
                end
            end
        end

        always_comb begin
            flg_nxt[i] = 3'h0;
            if (live) begin
                flg_nxt[i] = (cnt_r[i] > cmp_r[i]) ? 3'h1 : (cnt_r[i] == cmp_r[i]) ? 3'h2 : 3'h4;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= '0;
            en_prev_r <= 8'h00;
            flags_r <= '0;
            for (int k = 0; k < `TEC_NUM; k++) begin
                cnt_r[k] <= `TEC_RST_VAL;
                frz_r[k] <= `TEC_RST_VAL;
                ftm_r[k] <= `TEC_RST_VAL;
            end
        end else begin
            prev_r <= ops;
            en_prev_r <= en_r;
            for (int k = 0; k < `TEC_NUM; k++) begin
                cnt_r[k] <= cnt_nxt[k];
                frz_r[k] <= frz_nxt[k];
                ftm_r[k] <= ftm_nxt[k];
                flags_r.count_above_compare[k] <= flg_nxt[k][0];
                flags_r.count_equals_compare[k] <= flg_nxt[k][1];
                flags_r.count_under_compare[k] <= flg_nxt[k][2];
            end
        end
    end

    assign flags = flags_r;

endmodule : tec_top
